// >>> core/gpio_port_regs.svh
// Register offsets, field positions, reset values and timing counts of the I/O port set.
// Assumes byte addresses on a 32-bit APB with one aligned word per register.
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
`define OFS_P0_LATCH      12'h000
`define OFS_P0_CFG_A      12'h004
`define OFS_P0_CFG_B      12'h008
`define OFS_P1_LATCH      12'h00C
`define OFS_P1_CFG_A      12'h010
`define OFS_P1_CFG_B      12'h014
`define OFS_P3_LATCH      12'h018
`define OFS_P3_CFG_A      12'h01C
`define OFS_P3_CFG_B      12'h020
`define OFS_P0_ANALOG_DIS 12'h024
`define OFS_P0_LEVEL      12'h028
`define OFS_P1_LEVEL      12'h02C
`define OFS_P3_LEVEL      12'h030
`define OFS_OPTIONS       12'h034
`define OFS_PIN_COUNT     12'h038

////////////////////////////////////////////////////////////////////////////////
`define RST_LATCH         18'h3FFFF
`define RST_CFG_A         18'h3FFFF
`define RST_CFG_B         18'h00000
`define RST_ANALOG_DIS    8'h00
`define RST_OPTIONS       3'h0
`define ANALOG_DIS_MASK   8'h3E
`define CFG_A_FORCE_ONE   18'h02C00
`define CFG_B_FORCE_ZERO  18'h02000
`define OPT_RST_BIT       0
`define OPT_CLK_MSB       2
`define OPT_CLK_LSB       1
`define PIN_RESET_SHARED  13
`define PIN_XTAL_OUT      16
`define PIN_XTAL_IN       17
`define PINS_MAX          5'h12

////////////////////////////////////////////////////////////////////////////////
`define CFG_QUASI         2'h0
`define CFG_PUSH_PULL     2'h1
`define CFG_INPUT_ONLY    2'h2
`define CFG_OPEN_DRAIN    2'h3
`define FILTER_CYCLES     2

`endif

// >>> core/gpio_port_pkg.sv
// Types shared by the I/O port set.
// Assumes the constant header is on the include path.
`include "gpio_port_regs.svh"

package gpio_port_pkg;

   typedef enum logic [1:0] {
      QUASI,
      PUSH_PULL,
      INPUT_ONLY,
      OPEN_DRAIN
   } pin_type_e;

   function automatic pin_type_e decode_type(input logic [1:0] pair);
      pin_type_e t;
      t = INPUT_ONLY;
      if (pair == `CFG_QUASI) begin
         t = QUASI;
      end else if (pair == `CFG_PUSH_PULL) begin
         t = PUSH_PULL;
      end else if (pair == `CFG_OPEN_DRAIN) begin
         t = OPEN_DRAIN;
      end
      return t;
   endfunction

endpackage

// >>> core/pin_input_filter.sv
// Glitch-suppressing input stage for one pin.
// Assumes the pin level is already synchronous to the core clock.
`timescale 1ns/1ps

module pin_input_filter #(
   parameter int CYCLES = 2
) (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic raw_in,
   input  wire logic enable_in,
   output logic      level_out
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] run;
   logic          differs;
   logic          settle;

   // A disabled buffer is held low so an analog level cannot toggle logic.
   assign differs = enable_in & (raw_in != level_out);
   assign settle  = differs & (run == CW'(CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         run       <= '0;
         level_out <= 1'b0;
      end else if (!enable_in) begin
         run       <= '0;
         level_out <= 1'b0;
      end else if (settle) begin
         run       <= '0;
         level_out <= raw_in;
      end else if (differs) begin
         run       <= run + CW'(1);
      end else begin
         run       <= '0;
      end
   end

endmodule

// >>> core/configurable_io_port_set.sv
// Two 8-bit ports and one 2-bit port with per-bit output types, behind an APB slave.
// Assumes pin levels arrive synchronous to core_clk_in and the pad applies the enables.
`timescale 1ns/1ps
`include "gpio_port_regs.svh"

module configurable_io_port_set #(
   parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic [7:0]  port0_pin_in,
   output logic      [7:0]  port0_pin_out,
   output logic      [7:0]  port0_pin_oe_n_out,
   output logic      [7:0]  port0_weak_pullup_out,
   input  wire logic [7:0]  port1_pin_in,
   output logic      [7:0]  port1_pin_out,
   output logic      [7:0]  port1_pin_oe_n_out,
   output logic      [7:0]  port1_weak_pullup_out,
   input  wire logic [1:0]  port3_pin_in,
   output logic      [1:0]  port3_pin_out,
   output logic      [1:0]  port3_pin_oe_n_out,
   output logic      [1:0]  port3_weak_pullup_out,
   output logic             reset_pin_request_out
);

   localparam int NPINS = 18;

   logic [17:0] latch;
   logic [17:0] cfg_a;
   logic [17:0] cfg_b;
   logic [7:0]  port0_digital_input_disable;
   logic [2:0]  options;
   logic [17:0] pad_out;
   logic [17:0] pad_oe_n;
   logic [17:0] weak_pu;
   logic [17:0] level;
   logic [17:0] taken;
   logic [17:0] buf_en;
   logic [17:0] qb_act;
   logic [17:0] pp_act;
   logic [17:0] od_act;
   logic [17:0] next_latch;
   logic [17:0] next_cfg_a;
   logic [17:0] next_cfg_b;
   logic [17:0] next_pad_out;
   logic [17:0] next_pad_oe_n;
   logic [17:0] next_weak_pu;
   logic [17:0] pins_raw;
   logic [7:0]  next_analog;
   logic [2:0]  next_options;
   logic [4:0]  pin_count;
   logic [1:0]  clk_taken;
   logic [7:0]  rd_byte;
   logic        rd_hit;
   logic        access;
   logic        wr_acc;
   logic [7:0]  wd;
   gpio_port_pkg::pin_type_e pin_type [NPINS];

   ////////////////////////////////////////////////////////////////////////////////
   // APB: one wait state, so every access completes on the second access-phase edge.
   assign access = psel_in & penable_in & pready_out;
   assign wr_acc = access & pwrite_in & pstrb_in[0];
   assign wd     = pwdata_in[7:0];

   wire we_p0_latch = wr_acc & (paddr_in == `OFS_P0_LATCH);
   wire we_p0_cfg_a = wr_acc & (paddr_in == `OFS_P0_CFG_A);
   wire we_p0_cfg_b = wr_acc & (paddr_in == `OFS_P0_CFG_B);
   wire we_p1_latch = wr_acc & (paddr_in == `OFS_P1_LATCH);
   wire we_p1_cfg_a = wr_acc & (paddr_in == `OFS_P1_CFG_A);
   wire we_p1_cfg_b = wr_acc & (paddr_in == `OFS_P1_CFG_B);
   wire we_p3_latch = wr_acc & (paddr_in == `OFS_P3_LATCH);
   wire we_p3_cfg_a = wr_acc & (paddr_in == `OFS_P3_CFG_A);
   wire we_p3_cfg_b = wr_acc & (paddr_in == `OFS_P3_CFG_B);
   wire we_analog   = wr_acc & (paddr_in == `OFS_P0_ANALOG_DIS);
   wire we_options  = wr_acc & (paddr_in == `OFS_OPTIONS);

   // Pins are flattened: [7:0] port 0, [15:8] port 1, [17:16] port 3.
   assign pins_raw   = {port3_pin_in, port1_pin_in, port0_pin_in};
   assign next_latch = {we_p3_latch ? wd[1:0] : latch[17:16],
                        we_p1_latch ? wd : latch[15:8],
                        we_p0_latch ? wd : latch[7:0]};

   // Restricted pins keep a one in their first type bit, so only input-only
   // and open-drain can ever be stored for them; a write of another type is stored with that bit set.
   assign next_cfg_a = {we_p3_cfg_a ? wd[1:0] : cfg_a[17:16],
                        we_p1_cfg_a ? wd : cfg_a[15:8],
                        we_p0_cfg_a ? wd : cfg_a[7:0]} | `CFG_A_FORCE_ONE;
   assign next_cfg_b = {we_p3_cfg_b ? wd[1:0] : cfg_b[17:16],
                        we_p1_cfg_b ? wd : cfg_b[15:8],
                        we_p0_cfg_b ? wd : cfg_b[7:0]} & ~`CFG_B_FORCE_ZERO;
   assign next_analog  = we_analog ? (wd & `ANALOG_DIS_MASK) : port0_digital_input_disable;
   assign next_options = we_options ? wd[2:0] : options;

   ////////////////////////////////////////////////////////////////////////////////
   // Pins lost to the clock and reset options.
   assign clk_taken = options[`OPT_CLK_MSB] ? 2'h3 : (options[`OPT_CLK_LSB] ? 2'h2 : 2'h0);
   assign taken = {clk_taken, 2'h0, options[`OPT_RST_BIT], 13'h0000};
   assign pin_count = `PINS_MAX - 5'(options[`OPT_RST_BIT])
                      - 5'(clk_taken[0]) - 5'(clk_taken[1]);

   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      if (paddr_in == `OFS_P0_LATCH) begin
         rd_byte = latch[7:0];
      end else if (paddr_in == `OFS_P0_CFG_A) begin
         rd_byte = cfg_a[7:0];
      end else if (paddr_in == `OFS_P0_CFG_B) begin
         rd_byte = cfg_b[7:0];
      end else if (paddr_in == `OFS_P1_LATCH) begin
         rd_byte = latch[15:8];
      end else if (paddr_in == `OFS_P1_CFG_A) begin
         rd_byte = cfg_a[15:8];
      end else if (paddr_in == `OFS_P1_CFG_B) begin
         rd_byte = cfg_b[15:8];
      end else if (paddr_in == `OFS_P3_LATCH) begin
         rd_byte = {6'h00, latch[17:16]};
      end else if (paddr_in == `OFS_P3_CFG_A) begin
         rd_byte = {6'h00, cfg_a[17:16]};
      end else if (paddr_in == `OFS_P3_CFG_B) begin
         rd_byte = {6'h00, cfg_b[17:16]};
      end else if (paddr_in == `OFS_P0_ANALOG_DIS) begin
         rd_byte = port0_digital_input_disable;
      end else if (paddr_in == `OFS_P0_LEVEL) begin
         rd_byte = level[7:0];
      end else if (paddr_in == `OFS_P1_LEVEL) begin
         rd_byte = level[15:8];
      end else if (paddr_in == `OFS_P3_LEVEL) begin
         rd_byte = {6'h00, level[17:16]};
      end else if (paddr_in == `OFS_OPTIONS) begin
         rd_byte = {5'h00, options};
      end else if (paddr_in == `OFS_PIN_COUNT) begin
         rd_byte = {3'h0, pin_count};
      end else begin
         rd_hit  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-pin type decode, drivers and input stage.
   genvar i;
   generate
      for (i = 0; i < NPINS; i = i + 1) begin : g_pin
         assign pin_type[i] = taken[i] ? gpio_port_pkg::INPUT_ONLY
                            : gpio_port_pkg::decode_type({cfg_a[i], cfg_b[i]});
         assign qb_act[i] = (pin_type[i] == gpio_port_pkg::QUASI);
         assign pp_act[i] = (pin_type[i] == gpio_port_pkg::PUSH_PULL);
         assign od_act[i] = (pin_type[i] == gpio_port_pkg::OPEN_DRAIN);
         // Quasi and open-drain sink only on a zero latch; input-only never drives.
         assign next_pad_oe_n[i] = pp_act[i] ? 1'b0
                                 : ((qb_act[i] | od_act[i]) ? latch[i] : 1'b1);
         assign next_pad_out[i]  = pp_act[i] & latch[i];
         assign next_weak_pu[i]  = qb_act[i] & latch[i];
         if (i < 8) begin : g_analog
            assign buf_en[i] = ~port0_digital_input_disable[i];
         end else begin : g_plain
            assign buf_en[i] = 1'b1;
         end
         pin_input_filter #(
            .CYCLES   (FILTER_CYCLES)
         ) u_filter (
            .core_clk_in (core_clk_in),
            .rst_in      (rst_in),
            .raw_in      (pins_raw[i]),
            .enable_in   (buf_en[i]),
            .level_out   (level[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         latch                       <= `RST_LATCH;
         cfg_a                       <= `RST_CFG_A;
         cfg_b                       <= `RST_CFG_B;
         port0_digital_input_disable <= `RST_ANALOG_DIS;
         options                     <= `RST_OPTIONS;
      end else begin
         latch                       <= next_latch;
         cfg_a                       <= next_cfg_a;
         cfg_b                       <= next_cfg_b;
         port0_digital_input_disable <= next_analog;
         options                     <= next_options;
      end
   end

   // Drivers are registered so the pads never see decode glitches; this costs one cycle.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pad_out  <= 18'h00000;
         pad_oe_n <= 18'h3FFFF;
         weak_pu  <= 18'h00000;
      end else begin
         pad_out  <= next_pad_out;
         pad_oe_n <= next_pad_oe_n;
         weak_pu  <= next_weak_pu;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h00000000;
         pslverr_out <= 1'b0;
      end else if (psel_in && penable_in && !pready_out) begin
         pready_out  <= 1'b1;
         prdata_out  <= pwrite_in ? 32'h00000000 : {24'h000000, rd_byte};
         pslverr_out <= ~rd_hit;
      end else begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h00000000;
         pslverr_out <= 1'b0;
      end
   end

   // The reset-shared pin asks for a reset while enabled and filtered low.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         reset_pin_request_out <= 1'b0;
      end else begin
         reset_pin_request_out <= options[`OPT_RST_BIT] & ~level[`PIN_RESET_SHARED];
      end
   end

   assign port0_pin_out         = pad_out[7:0];
   assign port0_pin_oe_n_out    = pad_oe_n[7:0];
   assign port0_weak_pullup_out = weak_pu[7:0];
   assign port1_pin_out         = pad_out[15:8];
   assign port1_pin_oe_n_out    = pad_oe_n[15:8];
   assign port1_weak_pullup_out = weak_pu[15:8];
   assign port3_pin_out         = pad_out[17:16];
   assign port3_pin_oe_n_out    = pad_oe_n[17:16];
   assign port3_weak_pullup_out = weak_pu[17:16];

   ////////////////////////////////////////////////////////////////////////////////
   a_reset_pin_input: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pad_oe_n[`PIN_RESET_SHARED] && !weak_pu[`PIN_RESET_SHARED])
      else $error("reset-shared pin was driven");

   a_serial_no_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cfg_a[11:10] == 2'h3 |=> (pad_out[11:10] == 2'h0) && (weak_pu[11:10] == 2'h0))
      else $error("serial pin took a type that drives high");

   a_push_pull_drive: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> (((pad_out ^ $past(latch)) & $past(pp_act)) == 18'h00000)
               && ((pad_oe_n & $past(pp_act)) == 18'h00000))
      else $error("push-pull pin not driving its latch");

   a_open_drain_sink: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> (((pad_oe_n ^ $past(latch)) & $past(od_act)) == 18'h00000)
               && (((pad_out | weak_pu) & $past(od_act)) == 18'h00000))
      else $error("open-drain pin pulled up or sank on a one");

   a_quasi_weak_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> ((weak_pu ^ ($past(latch) & $past(qb_act))) & $past(qb_act)) == 18'h00000
               && ((pad_oe_n ^ $past(latch)) & $past(qb_act)) == 18'h00000)
      else $error("quasi pin not weak high on one and strong low on zero");

   a_input_only_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> ((~pad_oe_n | weak_pu) & ~$past(pp_act | od_act | qb_act)) == 18'h00000)
      else $error("input-only pin has a driver on");

   a_taken_pins_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> ((~pad_oe_n | weak_pu) & $past(taken)) == 18'h00000)
      else $error("pin taken by a clock or reset option still driven");

   a_analog_disable: assert property (@(posedge core_clk_in) disable iff (rst_in)
      port0_digital_input_disable[3] [*2] |-> level[3] == 1'b0)
      else $error("disabled port 0 input still reaches the logic");

   a_analog_mask: assert property (@(posedge core_clk_in) disable iff (rst_in)
      we_analog |=> port0_digital_input_disable == ($past(wd) & `ANALOG_DIS_MASK))
      else $error("analog-select write kept a bit outside 1 to 5");

   a_reset_defaults: assert property (@(posedge core_clk_in)
      rst_in |=> (port0_digital_input_disable == 8'h00) && (cfg_a == 18'h3FFFF)
                 && (cfg_b == 18'h00000) && (pad_oe_n == 18'h3FFFF))
      else $error("reset did not restore input-only and enabled inputs");

   a_pin_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $countones(taken) + int'(pin_count) == NPINS)
      else $error("available pin count disagrees with pins taken");

   a_filter_delay: assert property (@(posedge core_clk_in) disable iff (rst_in)
      buf_en[8] && (pins_raw[8] != level[8]) && !$stable(pins_raw[8])
      |=> level[8] == $past(level[8]))
      else $error("input passed without glitch suppression");

   a_cfg_write_lands: assert property (@(posedge core_clk_in) disable iff (rst_in)
      we_p0_cfg_a |=> cfg_a[7:0] == $past(wd))
      else $error("port 0 type write did not land");

   a_request_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !options[`OPT_RST_BIT] |=> !reset_pin_request_out)
      else $error("reset request raised with the reset pin disabled");

   // Bus checks: each answer is a one-cycle pready pulse, and data and error show only in that cycle.
   a_ready_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pready_out |=> !pready_out)
      else $error("pready held for more than one cycle");

   a_read_idle_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !pready_out |-> (prdata_out == 32'h00000000) && !pslverr_out)
      else $error("read data or error shown outside the answer cycle");

   a_unmapped_error: assert property (@(posedge core_clk_in) disable iff (rst_in)
      psel_in && penable_in && !pready_out && !rd_hit
      |=> pslverr_out && (prdata_out == 32'h00000000))
      else $error("unmapped address answered without an error");

   // A write without its low strobe is answered but must leave the latch and type registers alone.
   a_strobe_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in)
      access && pwrite_in && !pstrb_in[0] |=> (latch == $past(latch))
      && (cfg_a == $past(cfg_a)) && (cfg_b == $past(cfg_b)))
      else $error("write without its low byte strobe changed a register");

   a_apb_one_wait: assert property (@(posedge core_clk_in) disable iff (rst_in)
      psel_in && penable_in && !pready_out |=> pready_out)
      else $error("apb access not answered after one wait state");

endmodule

// >>> verification/pin_partner_model.sv
// Board-side model of the parts wired to the eighteen port pins.
// Assumes every pin has a board pull-up and that the bench may ground any pin on request.
`timescale 1ns/1ps

module pin_partner_model (
   input  wire logic [17:0] drive_in,
   input  wire logic [17:0] oe_n_in,
   input  wire logic [17:0] ext_low_in,
   output logic      [17:0] level_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // A strong drive from the device wins; otherwise an outside part may sink the pin.
   // A released pin rises to the pull-up, so it never keeps its last driven value.
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         if (oe_n_in[i] == 1'b0) begin
            level_out[i] = drive_in[i];
         end else if (ext_low_in[i] == 1'b1) begin
            level_out[i] = 1'b0;
         end else begin
            level_out[i] = 1'b1;
         end
      end
   end

endmodule

// >>> verification/configurable_io_port_set_tb_top.sv
// Self-checking bench of the I/O port set: APB master, pin model and read scoreboard.
// Assumes the constant header is on the include path and a filter of two cycles.
`timescale 1ns/1ps
`include "gpio_port_regs.svh"

module configurable_io_port_set_tb_top;

   typedef struct packed {logic rd; logic err; logic [31:0] data;} note_s;

   logic        core_clk_in = 1'b0;
   logic        rst_in      = 1'b1;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0;
   logic [3:0]  pstrb       = 4'h0;
   logic [17:0] ext_low     = 18'h0;
   logic [31:0] seed        = 32'd98;
   wire  [31:0] prdata_out;
   wire         pready_out;
   wire         pslverr_out;
   wire         reset_pin_request_out;
   wire  [17:0] pin_in;
   wire  [17:0] pin_out;
   wire  [17:0] pin_oe_n;
   wire  [17:0] pin_weak;
   note_s       notes[$];
   int          fails      = 0;
   int          num_checks = 0;
   int          cyc        = 0;

   always #50 core_clk_in = ~core_clk_in;

   configurable_io_port_set #(.FILTER_CYCLES(2)) dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .port0_pin_in(pin_in[7:0]), .port0_pin_out(pin_out[7:0]),
      .port0_pin_oe_n_out(pin_oe_n[7:0]), .port0_weak_pullup_out(pin_weak[7:0]),
      .port1_pin_in(pin_in[15:8]), .port1_pin_out(pin_out[15:8]),
      .port1_pin_oe_n_out(pin_oe_n[15:8]), .port1_weak_pullup_out(pin_weak[15:8]),
      .port3_pin_in(pin_in[17:16]), .port3_pin_out(pin_out[17:16]),
      .port3_pin_oe_n_out(pin_oe_n[17:16]), .port3_weak_pullup_out(pin_weak[17:16]),
      .reset_pin_request_out(reset_pin_request_out));

   pin_partner_model u_partner (.drive_in(pin_out), .oe_n_in(pin_oe_n),
      .ext_low_in(ext_low), .level_out(pin_in));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // The request is held until pready is seen at an edge; no wait count is assumed.
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge core_clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_in);
      end while (pready_out !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic e = 1'b0);
      notes.push_back('{1'b0, e, 32'h0});
      bus(1'b1, a, d, s);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e = 1'b0);
      notes.push_back('{1'b1, e, exp});
      bus(1'b0, a, 32'h0, 4'h0);
   endtask

   // Output flops follow one edge after the write edge, so two edges settle them.
   task automatic pin_chk(input logic [17:0] oe, input logic [17:0] wk, input logic [17:0] drv);
      repeat (2) @(posedge core_clk_in);
      check({15'h0, pin_oe_n}, {15'h0, oe});
      check({15'h0, pin_weak}, {15'h0, wk});
      check({15'h0, pin_out & ~pin_oe_n}, {15'h0, drv});
   endtask

   task automatic reset_chk;
      rd(`OFS_P0_CFG_A, 32'hFF);
      rd(`OFS_P1_CFG_B, 32'h00);
      rd(`OFS_P3_LATCH, 32'h03);
      rd(`OFS_P0_ANALOG_DIS, 32'h00);
      rd(`OFS_PIN_COUNT, 32'd18);
      pin_chk(18'h3FFFF, 18'h0, 18'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_in) begin
      if (pready_out === 1'b1) begin
         if (notes.size() == 0) begin
            check(33'h1, 33'h0);
         end else if (notes[0].rd) begin
            check({pslverr_out, prdata_out}, {notes[0].err, notes[0].data});
            void'(notes.pop_front());
         end else begin
            check({pslverr_out, 32'h0}, {notes[0].err, 32'h0});
            void'(notes.pop_front());
         end
      end
   end

   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0]  t;
      logic [7:0]  l0;
      logic [7:0]  r;
      logic [17:0] lat;
      logic [17:0] oe;
      repeat (4) @(posedge core_clk_in);
      rst_in <= 1'b0;
      reset_chk;
      $display("reset test done");
      for (int p = 0; p < 4; p++) begin
         t = p[1:0];
         seed = xorshift(seed);
         l0 = seed[7:0];
         lat = {seed[9:8], 8'h00, l0};
         wr(`OFS_P0_LATCH, {24'h0, l0});
         wr(`OFS_P3_LATCH, {30'h0, seed[9:8]});
         wr(`OFS_P0_CFG_A, {24'h0, {8{t[1]}}});
         wr(`OFS_P0_CFG_B, {24'h0, {8{t[0]}}});
         wr(`OFS_P3_CFG_A, {30'h0, {2{t[1]}}});
         wr(`OFS_P3_CFG_B, {30'h0, {2{t[0]}}});
         rd(`OFS_P0_CFG_B, {24'h0, {8{t[0]}}});
         oe = (t == 2'h1) ? 18'h0FF00 : (t == 2'h2) ? 18'h3FFFF : (lat | 18'h0FF00);
         pin_chk(oe, (t == 2'h0) ? lat : 18'h0, (t == 2'h1) ? lat : 18'h0);
         repeat (4) @(posedge core_clk_in);
         rd(`OFS_P0_LEVEL, (t == 2'h2) ? 32'hFF : {24'h0, l0});
      end
      $display("pin type test done");
      seed = xorshift(seed);
      wr(`OFS_P1_LATCH, {24'h0, seed[7:0]});
      wr(`OFS_P1_CFG_A, 32'h00);
      wr(`OFS_P1_CFG_B, 32'hFF);
      rd(`OFS_P1_CFG_A, 32'h2C);
      rd(`OFS_P1_CFG_B, 32'hDF);
      oe = {2'h0, (seed[7:0] & 8'h0C) | 8'h20, 8'h00} | (lat & 18'h300FF);
      pin_chk(oe, 18'h0, {2'h0, seed[7:0] & 8'hD3, 8'h00});
      $display("restricted pin test done");
      // Analog pins are parked as inputs first so no driver fights the analog source.
      wr(`OFS_P0_CFG_A, 32'hFF);
      wr(`OFS_P0_CFG_B, 32'h00);
      r = seed[15:8];
      ext_low[7:0] <= r;
      repeat (4) @(posedge core_clk_in);
      rd(`OFS_P0_LEVEL, {24'h0, ~r});
      @(posedge core_clk_in);
      ext_low[7:0] <= r ^ 8'h81;
      @(posedge core_clk_in);
      ext_low[7:0] <= r;
      repeat (4) @(posedge core_clk_in);
      rd(`OFS_P0_LEVEL, {24'h0, ~r});
      wr(`OFS_P0_ANALOG_DIS, 32'hFF);
      rd(`OFS_P0_ANALOG_DIS, 32'h3E);
      rd(`OFS_P0_LEVEL, {24'h0, ~r & 8'hC1});
      $display("input path test done");
      for (int o = 0; o < 8; o++) begin
         wr(`OFS_OPTIONS, o);
         rd(`OFS_PIN_COUNT, 18 - o[0] - (o[2] ? 2 : o[1]));
      end
      wr(`OFS_OPTIONS, 32'h1);
      ext_low[13] <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      check({32'h0, reset_pin_request_out}, 33'h1);
      ext_low[13] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      check({32'h0, reset_pin_request_out}, 33'h0);
      $display("pin option test done");
      rd(12'h03C, 32'h0, 1'b1);
      wr(12'hFFC, 32'h0, 4'hF, 1'b1);
      wr(`OFS_P1_LATCH, 32'h00, 4'h0);
      rd(`OFS_P1_LATCH, {24'h0, seed[7:0]});
      $display("refusal test done");
      rst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      reset_chk;
      $display("second reset test done");
      repeat (3) @(posedge core_clk_in);
      give_verdict;
   end

endmodule
